// [bench/dhc_host.sv]
`timescale 1ns/1ps
module dhc_host (
  input wire logic i_clk,
  input wire logic i_tx_valid,
  input wire logic i_slow,
  output logic o_tx_ready,
  output int o_acks
);
  int n = 0;
  int acks_q = 0;
  // slow mode stalls the ack character three cycles
  assign o_tx_ready = i_tx_valid && (!i_slow || n >= 3);
  assign o_acks = acks_q;
  always @(posedge i_clk) begin
    n <= i_tx_valid ? n + 1 : 0;
    if (o_tx_ready) acks_q <= acks_q + 1;
  end
endmodule

// [bench/dhc_props.sv]
`timescale 1ns/1ps
module dhc_props #(parameter int RC = 16) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cmd_valid,
  input wire logic i_opcode_valid,
  input wire logic i_read_protect,
  input wire logic i_write_protect,
  input wire logic i_sector_protect,
  input wire logic i_flash_via_debug,
  input wire logic o_fetch_stop,
  input wire logic o_brk_nop,
  input wire logic o_tx_valid,
  input wire logic o_sys_rst,
  input wire logic o_flash_wp_eff,
  input wire logic o_flash_sp_eff,
  input wire logic [7:0] i_cmd_code,
  input wire logic [7:0] i_cmd_data,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] o_ctrl_rdata,
  input wire logic [7:0] o_tx_data
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire wr = i_cmd_valid && i_cmd_code == 8'h04;
  wire bk = i_opcode_valid && i_opcode == 8'h00;
  property p_hold; o_fetch_stop && (i_read_protect || !wr || i_cmd_data[7]) |=> o_fetch_stop; endproperty
  a_hold: assert property (p_hold) else $error("halt lost");
  property p_clr; o_fetch_stop && wr && !i_cmd_data[7] && !i_read_protect |=> !o_fetch_stop; endproperty
  a_clr: assert property (p_clr) else $error("halt kept");
  property p_set; $rose(o_fetch_stop) |-> $past(wr && i_cmd_data[7] || bk); endproperty
  a_set: assert property (p_set) else $error("halt cause");
  property p_nop; o_brk_nop |-> $past(bk) && !$rose(o_tx_valid); endproperty
  a_nop: assert property (p_nop) else $error("nop");
  property p_ack; $rose(o_tx_valid) |-> $rose(o_fetch_stop); endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_res; o_ctrl_rdata[4:1] == 4'h0 && o_tx_data == 8'hff; endproperty
  a_res: assert property (p_res) else $error("reserved");
  property p_rst; $rose(o_sys_rst) |-> $past(wr && i_cmd_data[0]); endproperty
  a_rst: assert property (p_rst) else $error("sys reset");
  property p_len; $fell(o_sys_rst) |-> $past(o_sys_rst, RC + 1) && !$past(o_sys_rst, RC + 2); endproperty
  a_len: assert property (p_len) else $error("reset length");
  property p_wp; $past(i_nrst) |-> o_flash_wp_eff == $past(i_write_protect && !i_flash_via_debug); endproperty
  a_wp: assert property (p_wp) else $error("wp");
  property p_sp; $past(i_nrst) |-> o_flash_sp_eff == $past(i_sector_protect && !i_flash_via_debug); endproperty
  a_sp: assert property (p_sp) else $error("sp");
endmodule
bind dhc_debug_halt_control dhc_props #(.RC(RST_CYCLES)) dhc_props_inst (.*);

// [bench/tb_dhc_debug_halt_control.sv]
`timescale 1ns/1ps
module tb_dhc_debug_halt_control;
  logic i_clk = 0, i_nrst = 0, cv = 0, rd = 0, ov = 0, rp = 0, wp = 1, sp = 1, fv = 0, slow = 1;
  logic [7:0] cc = 0, cd = 0, od = 8'h11, v, td;
  logic fs, bn, tv, sr, we, se, tr;
  int err_count = 0, checks_done = 0, cyc = 0, acks;
  dhc_debug_halt_control #(.RST_CYCLES(4)) dhc_debug_halt_control_inst (.i_clk, .i_nrst, .i_cmd_valid(cv),
    .i_cmd_code(cc), .i_cmd_data(cd), .i_rd_ctrl(rd), .i_opcode_valid(ov), .i_opcode(od), .i_read_protect(rp),
    .i_write_protect(wp), .i_sector_protect(sp), .i_flash_via_debug(fv), .i_tx_ready(tr), .o_ctrl_rdata(v),
    .o_fetch_stop(fs), .o_brk_nop(bn), .o_tx_valid(tv), .o_tx_data(td), .o_sys_rst(sr),
    .o_flash_wp_eff(we), .o_flash_sp_eff(se));
  dhc_host dhc_host_inst (.i_clk, .i_tx_valid(tv), .i_slow(slow), .o_tx_ready(tr), .o_acks(acks));
  initial forever #5 i_clk = ~i_clk;
  task end_of_test;
    $display("counts %0d %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end
  task chk(input logic [7:0] a, e);
    checks_done++;
    if (a !== e) begin
      err_count++;
      $display("wrong value %0t got %h exp %h", $time, a, e);
    end
  endtask
  task wr(input logic [7:0] c, d);
    @(negedge i_clk) {cv, cc, cd} = {1'b1, c, d};
    @(negedge i_clk) cv = 0;
  endtask
  task op(input logic [7:0] o);
    @(negedge i_clk) {ov, od} = {1'b1, o};
    @(negedge i_clk) ov = 0;
  endtask
  task rdc(input logic [7:0] e);
    @(negedge i_clk) rd = 1;
    @(negedge i_clk) rd = 0;
    chk(v, e);
  endtask
  task t_regs;
    rdc(8'h00);
    wr(8'h04, 8'h3e);
    rdc(8'h20);
    wr(8'h05, 8'hc1);
    rdc(8'h20);
    op(8'h00);
    chk(bn, 1);
    chk(fs, 0);
    $display("regs done");
  endtask
  task t_brk;
    wr(8'h04, 8'h60);
    op(8'h11);
    chk(fs, 0);
    op(8'h00);
    chk(fs, 1);
    chk(tv, 1);
    chk(td, 8'hff);
    rp = 1;
    wr(8'h04, 8'h60);
    repeat (4) @(negedge i_clk);
    chk(fs, 1);
    chk(acks, 1);
    rp = 0;
    wr(8'h04, 8'h40);
    chk(fs, 0);
    op(8'h00);
    repeat (5) @(negedge i_clk);
    chk(acks, 1);
    wr(8'h04, 8'h00);
    $display("brk done");
  endtask
  task t_rst;
    wr(8'h04, 8'h41);
    chk(sr, 1);
    wr(8'h04, 8'h40);
    rdc(8'h41);
    repeat (6) @(negedge i_clk);
    chk(sr, 0);
    rdc(8'h40);
    fv = 1;
    @(negedge i_clk) chk(we, 0);
    chk(se, 0);
    fv = 0;
    @(negedge i_clk) chk({we, se}, 2'b11);
    $display("rst done");
  endtask
  initial begin
    repeat (3) @(negedge i_clk);
    i_nrst = 1;
    t_regs();
    t_brk();
    t_rst();
    end_of_test();
  end
endmodule

// [hw/dhc_debug_halt_control.sv]
`timescale 1ns/1ps
module dhc_debug_halt_control
  import dhc_pkg::*;
#(
  parameter int RST_CYCLES = DHC_RST_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic [7:0] i_cmd_data,
  input wire logic i_rd_ctrl,
  input wire logic i_opcode_valid,
  input wire logic [7:0] i_opcode,
  input wire logic i_read_protect,
  input wire logic i_write_protect,
  input wire logic i_sector_protect,
  input wire logic i_flash_via_debug,
  input wire logic i_tx_ready,
  output logic [7:0] o_ctrl_rdata,
  output logic o_fetch_stop,
  output logic o_brk_nop,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_sys_rst,
  output logic o_flash_wp_eff,
  output logic o_flash_sp_eff
);
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] rdata_reg, rdata_next;
  logic tx_valid_reg, tx_valid_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic nop_reg, nop_next;
  logic wp_reg, wp_next;
  logic sp_reg, sp_next;
  logic sys_rst_reg, sys_rst_next;
  logic seq_rst, seq_done;
  logic wr_ctrl, brk_hit, brk_seen, rst_start;

  function automatic logic [7:0] dhc_readback(input logic [7:0] c);
    logic [7:0] r;
    r = 8'h00;
    r[DHC_BIT_HALT] = c[DHC_BIT_HALT];
    r[DHC_BIT_BREAKPOINT_ENABLE] = c[DHC_BIT_BREAKPOINT_ENABLE];
    r[DHC_BIT_ACKEN] = c[DHC_BIT_ACKEN];
    r[DHC_BIT_RST] = c[DHC_BIT_RST];
    return r;
  endfunction

  function automatic logic dhc_is_wr_ctrl(input logic valid, input logic [7:0] code);
    return valid && (code == DHC_CMD_WR_CTRL);
  endfunction

  function automatic logic dhc_is_brk(input logic valid, input logic [7:0] opc);
    return valid && (opc == DHC_BRK_OPCODE);
  endfunction

  assign wr_ctrl = dhc_is_wr_ctrl(i_cmd_valid, i_cmd_code);
  // no second breakpoint while already halted
  assign brk_seen = dhc_is_brk(i_opcode_valid, i_opcode) && !ctrl_reg[DHC_BIT_HALT];
  assign brk_hit = brk_seen && ctrl_reg[DHC_BIT_BREAKPOINT_ENABLE];
  // a request while a sequence is pending is dropped
  assign rst_start = wr_ctrl && i_cmd_data[DHC_BIT_RST] && !ctrl_reg[DHC_BIT_RST];

  // control register: halt, breakpoint enable, acknowledge enable, reset bit
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next[DHC_BIT_BREAKPOINT_ENABLE] = i_cmd_data[DHC_BIT_BREAKPOINT_ENABLE];
      ctrl_next[DHC_BIT_ACKEN] = i_cmd_data[DHC_BIT_ACKEN];
      if (i_cmd_data[DHC_BIT_HALT]) begin
        ctrl_next[DHC_BIT_HALT] = 1'h1;
      end else if (!i_read_protect) begin
        ctrl_next[DHC_BIT_HALT] = 1'h0;
      end
      if (i_cmd_data[DHC_BIT_RST]) begin
        ctrl_next[DHC_BIT_RST] = 1'h1;
      end
    end
    // breakpoint set wins over a host clear in the same cycle
    if (brk_hit) begin
      ctrl_next[DHC_BIT_HALT] = 1'h1;
    end
    // reset bit clears as the sequence ends
    if (seq_done) begin
      ctrl_next[DHC_BIT_RST] = 1'h0;
    end
    ctrl_next[4:1] = 4'h0;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_reg <= DHC_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // readback shows the register as it stands after this edge
  always_comb begin
    rdata_next = rdata_reg;
    if (i_rd_ctrl) begin
      rdata_next = dhc_readback(ctrl_next);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // acknowledge request stands until the transmitter takes it
  always_comb begin
    tx_valid_next = tx_valid_reg;
    tx_data_next = DHC_ACK_CHAR;
    if (tx_valid_reg && i_tx_ready) begin
      tx_valid_next = 1'h0;
    end
    if (brk_hit && ctrl_reg[DHC_BIT_ACKEN]) begin
      tx_valid_next = 1'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_valid_reg <= 1'h0;
      tx_data_reg <= DHC_ACK_CHAR;
    end else begin
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
    end
  end

  // breakpoint opcode retired as a no-operation while breakpoint enable is clear
  always_comb begin
    nop_next = 1'h0;
    if (brk_seen && !ctrl_reg[DHC_BIT_BREAKPOINT_ENABLE]) begin
      nop_next = 1'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      nop_reg <= 1'h0;
    end else begin
      nop_reg <= nop_next;
    end
  end

  // debugger access bypasses both flash protections
  always_comb begin
    wp_next = i_write_protect;
    sp_next = i_sector_protect;
    if (i_flash_via_debug) begin
      wp_next = 1'h0;
      sp_next = 1'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_reg <= 1'h0;
      sp_reg <= 1'h0;
    end else begin
      wp_reg <= wp_next;
      sp_reg <= sp_next;
    end
  end

  // device reset: request cycle, then the whole sequence
  always_comb begin
    sys_rst_next = 1'h0;
    if (rst_start || seq_rst) begin
      sys_rst_next = 1'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sys_rst_reg <= 1'h0;
    end else begin
      sys_rst_reg <= sys_rst_next;
    end
  end

  // times the device reset; the debug unit stays out of it
  dhc_rst_seq #(
    .CYCLES(RST_CYCLES)
  ) u_rst_seq (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_start(rst_start),
    .o_sys_rst(seq_rst),
    .o_done(seq_done)
  );

  assign o_ctrl_rdata = rdata_reg;
  assign o_fetch_stop = ctrl_reg[DHC_BIT_HALT];
  assign o_brk_nop = nop_reg;
  assign o_tx_valid = tx_valid_reg;
  assign o_tx_data = tx_data_reg;
  assign o_sys_rst = sys_rst_reg;
  assign o_flash_wp_eff = wp_reg;
  assign o_flash_sp_eff = sp_reg;
endmodule

// [hw/dhc_pkg.sv]
package dhc_pkg;
  // debug control register layout
  localparam int DHC_BIT_HALT = 7;
  localparam int DHC_BIT_BREAKPOINT_ENABLE = 6;
  localparam int DHC_BIT_ACKEN = 5;
  localparam int DHC_BIT_RST = 0;
  localparam logic [7:0] DHC_CTRL_RESET = 8'h00;
  localparam logic [7:0] DHC_BRK_OPCODE = 8'h00;
  localparam logic [7:0] DHC_ACK_CHAR = 8'hff;
  localparam logic [7:0] DHC_CMD_WR_CTRL = 8'h04;
  // cycles the reset sequencer runs after a debugger reset request; the device reset is held one cycle longer
  localparam int DHC_RST_CYCLES = 16;

  typedef enum logic [1:0] {
    DHC_RUN = 2'b00,
    DHC_SYSRST = 2'b01
  } dhc_rst_state_t;
endpackage

// [hw/dhc_rst_seq.sv]
`timescale 1ns/1ps
module dhc_rst_seq
  import dhc_pkg::*;
#(
  parameter int CYCLES = DHC_RST_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  output logic o_sys_rst,
  output logic o_done
);
  dhc_rst_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic done_reg, done_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    case (state_reg)
      DHC_RUN: begin
        if (i_start) begin
          state_next = DHC_SYSRST;
          cnt_next = 16'(CYCLES - 1);
        end
      end
      DHC_SYSRST: begin
        if (cnt_reg == 16'h0000) begin
          state_next = DHC_RUN;
          done_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      default: state_next = DHC_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= DHC_RUN;
      cnt_reg <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign o_sys_rst = (state_reg == DHC_SYSRST);
  assign o_done = done_reg;
endmodule
